// ==== hdl/gce_pkg.sv ====
// package: register map, field positions, codes and state types
package gce_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_TMR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_GATE_CTRL = 8'h04;
  localparam logic [7:0] ADDR_COUNT = 8'h08;
  localparam logic [7:0] ADDR_OSC_CTRL = 8'h0C;
  localparam logic [7:0] ADDR_OSC_CTRL_TWO = 8'h10;
  localparam logic [7:0] ADDR_IRQ = 8'h14;
  localparam logic [7:0] ADDR_CMP_CTRL = 8'h18;
  localparam logic [7:0] ADDR_CMP_VALUE = 8'h1C;
  // field positions
  localparam int BIT_TIMER_ON = 0;
  localparam int BIT_OSC_EN = 3;
  localparam int BIT_OSC_EN_T3 = 4;
  localparam int BIT_GATE_EN = 7;
  localparam int BIT_GATE_POL = 6;
  localparam int BIT_GATE_VAL = 2;
  localparam int BIT_IDLE_ON_SLEEP = 7;
  localparam int BIT_DRIVE_LSB = 4;
  localparam int BIT_ACTIVE_FLAG = 6;
  localparam int BIT_WARMUP = 3;
  localparam int BIT_OVF_FLAG = 0;
  localparam int BIT_OVF_IE = 1;
  localparam int BIT_ADC_EN = 4;
  // codes
  localparam logic [1:0] SCS_SECONDARY = 2'h1;
  localparam logic [1:0] DRIVE_HIGH = 2'h3;
  localparam logic [1:0] DRIVE_LOW = 2'h1;
  localparam logic [3:0] CMP_SPECIAL_EVENT = 4'hB;
  localparam logic [1:0] GSS_PIN = 2'h0;
  localparam logic [1:0] GSS_TIMER2 = 2'h1;
  localparam logic [1:0] GSS_CMP1 = 2'h2;
  localparam logic [1:0] GSS_CMP2 = 2'h3;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam logic [15:0] COUNT_STEP = 16'h0001;
  // clocking mode of the device, one-hot
  typedef enum logic [2:0] {
    MODE_PRIMARY = 3'b001,
    MODE_SECONDARY_RUN_MODE = 3'b010,
    MODE_SECONDARY_IDLE_MODE = 3'b100
  } gce_mode_type;
  // whole state of the core
  typedef struct packed {
    logic timer_on;
    logic osc_en;
    logic osc_en_t3;
    logic gate_enable;
    logic gate_polarity;
    logic [1:0] gate_source_select;
    logic [15:0] count;
    logic ovf_flag;
    logic ovf_ie;
    logic [15:0] cmp_val;
    logic [3:0] cmp_mode;
    logic adc_en;
    logic idle_on_sleep;
    logic [1:0] system_clock_select;
    logic [1:0] drive_cfg;
    logic warmup;
    gce_mode_type mode;
    logic match;
    logic adc_start;
    logic [31:0] rdata;
  } gce_core_type;
  // whole state of the gate selector
  typedef struct packed {
    logic [1:0] pin_s;
    logic [1:0] c1_s;
    logic [1:0] c2_s;
    logic [1:0] ck_s;
    logic ck_last;
    logic t2_match;
    logic t2_pulse;
  } gce_gsel_type;
  localparam gce_core_type CORE_RESET = '{default: '0, mode: MODE_PRIMARY};
  localparam gce_gsel_type GSEL_RESET = '{default: '0};
endpackage

// ==== hdl/gce_gate_if.sv ====
// interface: gate sources and controls between core and gate selector
interface gce_gate_if;
  logic gate_pin;
  logic cmp1;
  logic cmp2;
  logic clk_pin;
  logic [7:0] t2_count;
  logic [7:0] t2_period;
  logic polarity;
  logic [1:0] source;
  logic gate_level;
  logic gate_active;
  logic tick;
  modport sel (
    input gate_pin, cmp1, cmp2, clk_pin, t2_count, t2_period, polarity,
    source,
    output gate_level, gate_active, tick
  );
  modport core (
    output gate_pin, cmp1, cmp2, clk_pin, t2_count, t2_period, polarity,
    source,
    input gate_level, gate_active, tick
  );
endinterface

// ==== hdl/gce_gate_sel.sv ====
// gate selector: synchronisers, timer2 match pulse, source mux, clock edge
module gce_gate_sel
  import gce_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // gate sources and controls
  gce_gate_if.sel gif
);
  gce_gsel_type s_q;
  gce_gsel_type s_d;
  logic m_now;

  // two-stage synchronisers, only stage one feeds stage two
  always_comb begin
    s_d = s_q;
    m_now = (gif.t2_count == gif.t2_period);
    s_d.pin_s = {s_q.pin_s[0], gif.gate_pin};
    s_d.c1_s = {s_q.c1_s[0], gif.cmp1};
    s_d.c2_s = {s_q.c2_s[0], gif.cmp2};
    s_d.ck_s = {s_q.ck_s[0], gif.clk_pin};
    s_d.ck_last = s_q.ck_s[1];
    s_d.t2_match = m_now;
    // timer2 leaves its match as it resets: one cycle high
    s_d.t2_pulse = s_q.t2_match & ~m_now;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= GSEL_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // source mux and polarity
  always_comb begin
    case (gif.source)
      GSS_PIN: gif.gate_level = s_q.pin_s[1];
      GSS_TIMER2: gif.gate_level = s_q.t2_pulse;
      GSS_CMP1: gif.gate_level = s_q.c1_s[1];
      GSS_CMP2: gif.gate_level = s_q.c2_s[1];
      default: gif.gate_level = 1'b0;
    endcase
    gif.gate_active = gif.polarity ? gif.gate_level : ~gif.gate_level;
  end

  // rising edge of the synchronised timer clock pin
  assign gif.tick = s_q.ck_s[1] & ~s_q.ck_last;

  a_t2_pulse_once: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_q.t2_pulse |=> !s_q.t2_pulse)
    else $error("timer2 match pulse longer than one cycle");

  a_cmp2_high_src: assert property (
    @(posedge pclk) disable iff (!presetn)
    (gif.source == GSS_CMP2 && gif.polarity && s_q.c2_s[1])
      |-> gif.gate_active)
    else $error("comparator 2 high did not open the gate");
endmodule // gce_gate_sel

// ==== hdl/gce_counter.sv ====
// gated 16-bit counter with event clear, secondary oscillator control
// Summary of operation
// - osc on by enables, warmup, or clock select
// - oscillator keeps running in idle and sleep
// - clock select 01 enters secondary run mode
// - sleep with idle bit clear: secondary idle
// - active flag set only while secondary clocks
// - drive config 11 high, 01 low power
// - count climbs to FFFF, wraps to 0000
// - wrap sets flag; irq only when enabled
// - special event compare match clears the count
// - same trigger starts conversion when converter enabled
// - count write beats a coincident trigger clear
// - trigger clear never sets the overflow flag
// - gate enable puts counting under gate control
// - gate active counts edges, inactive holds
// - polarity bit picks active gate level
// - source 00 pin, 01 timer2, 10 comparator1
// - source 11 routes comparator 2 output
// - timer2 match pulse lasts one cycle
module gce_counter
  import gce_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // external and internal sources
  input wire logic timer_clk_pin,
  input wire logic gate_input_pin,
  input wire logic cmp1_out,
  input wire logic cmp2_out,
  input wire logic [7:0] timer2_count,
  input wire logic [7:0] timer2_period,
  // power management events, same clock
  input wire logic sleep_exec,
  input wire logic wake_event,
  input wire logic clock_fail,
  // oscillator and mode outputs
  output logic secondary_osc_enable,
  output logic osc_drive_high,
  output logic osc_drive_low,
  output logic secondary_run_mode,
  output logic secondary_idle_mode,
  output logic cpu_halt,
  // counter events
  output logic overflow_irq,
  output logic adc_start
);
  gce_core_type s_q;
  gce_core_type s_d;
  gce_gate_if gif ();

  logic wr;
  logic rd_setup;
  logic mapped;
  logic cnt_wr;
  logic irq_wr;
  logic osc_wr;
  logic scs_wr_sec;
  logic match_now;
  logic sev;
  logic inc;
  logic ovf_set;
  logic flag_active;
  logic [31:0] rd_mux;

  // sources into the gate selector
  assign gif.gate_pin = gate_input_pin;
  assign gif.cmp1 = cmp1_out;
  assign gif.cmp2 = cmp2_out;
  assign gif.clk_pin = timer_clk_pin;
  assign gif.t2_count = timer2_count;
  assign gif.t2_period = timer2_period;
  assign gif.polarity = s_q.gate_polarity;
  assign gif.source = s_q.gate_source_select;

  gce_gate_sel u_sel (
    .pclk(pclk),
    .presetn(presetn),
    .gif(gif.sel)
  );

  // bus decode; zero wait states, so pready is constant
  assign wr = psel & penable & pwrite;
  assign rd_setup = psel & ~penable;
  assign cnt_wr = wr & (paddr == ADDR_COUNT);
  assign irq_wr = wr & (paddr == ADDR_IRQ);
  assign osc_wr = wr & (paddr == ADDR_OSC_CTRL);
  assign scs_wr_sec = osc_wr & (pwdata[1:0] == SCS_SECONDARY);
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // address map check
  always_comb begin
    case (paddr)
      ADDR_TMR_CTRL, ADDR_GATE_CTRL, ADDR_COUNT, ADDR_OSC_CTRL,
      ADDR_OSC_CTRL_TWO, ADDR_IRQ, ADDR_CMP_CTRL, ADDR_CMP_VALUE:
        mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // special event: rising of the match, so a held match fires once
  assign match_now = s_q.timer_on & (s_q.cmp_mode == CMP_SPECIAL_EVENT)
    & (s_q.count == s_q.cmp_val);
  assign sev = match_now & ~s_q.match;

  // gate decides only when enabled
  assign inc = s_q.timer_on & gif.tick
    & (~s_q.gate_enable | gif.gate_active);
  assign ovf_set = inc & ~cnt_wr & ~sev & (s_q.count == COUNT_MAX);
  assign flag_active = (s_q.mode != MODE_PRIMARY);

  // read data, unmapped offsets read zero
  always_comb begin
    rd_mux = '0;
    case (paddr)
      ADDR_TMR_CTRL: begin
        rd_mux[BIT_TIMER_ON] = s_q.timer_on;
        rd_mux[BIT_OSC_EN] = s_q.osc_en;
        rd_mux[BIT_OSC_EN_T3] = s_q.osc_en_t3;
      end
      ADDR_GATE_CTRL: begin
        rd_mux[BIT_GATE_EN] = s_q.gate_enable;
        rd_mux[BIT_GATE_POL] = s_q.gate_polarity;
        rd_mux[BIT_GATE_VAL] = gif.gate_level;
        rd_mux[1:0] = s_q.gate_source_select;
      end
      ADDR_COUNT: rd_mux[15:0] = s_q.count;
      ADDR_OSC_CTRL: begin
        rd_mux[BIT_IDLE_ON_SLEEP] = s_q.idle_on_sleep;
        rd_mux[BIT_DRIVE_LSB +: 2] = s_q.drive_cfg;
        rd_mux[1:0] = s_q.system_clock_select;
      end
      ADDR_OSC_CTRL_TWO: begin
        rd_mux[BIT_ACTIVE_FLAG] = flag_active;
        rd_mux[BIT_WARMUP] = s_q.warmup;
      end
      ADDR_IRQ: begin
        rd_mux[BIT_OVF_FLAG] = s_q.ovf_flag;
        rd_mux[BIT_OVF_IE] = s_q.ovf_ie;
      end
      ADDR_CMP_CTRL: begin
        rd_mux[3:0] = s_q.cmp_mode;
        rd_mux[BIT_ADC_EN] = s_q.adc_en;
      end
      ADDR_CMP_VALUE: rd_mux[15:0] = s_q.cmp_val;
      default: rd_mux = '0;
    endcase
  end

  // next state of the whole core
  always_comb begin
    s_d = s_q;
    s_d.adc_start = 1'b0;
    s_d.match = match_now;
    if (rd_setup) begin
      s_d.rdata = rd_mux;
    end
    // register writes land at the access edge
    if (wr && paddr == ADDR_TMR_CTRL) begin
      s_d.timer_on = pwdata[BIT_TIMER_ON];
      s_d.osc_en = pwdata[BIT_OSC_EN];
      s_d.osc_en_t3 = pwdata[BIT_OSC_EN_T3];
    end
    if (wr && paddr == ADDR_GATE_CTRL) begin
      s_d.gate_enable = pwdata[BIT_GATE_EN];
      s_d.gate_polarity = pwdata[BIT_GATE_POL];
      s_d.gate_source_select = pwdata[1:0];
    end
    if (osc_wr) begin
      s_d.idle_on_sleep = pwdata[BIT_IDLE_ON_SLEEP];
      s_d.drive_cfg = pwdata[BIT_DRIVE_LSB +: 2];
      s_d.system_clock_select = pwdata[1:0];
    end
    if (wr && paddr == ADDR_OSC_CTRL_TWO) begin
      s_d.warmup = pwdata[BIT_WARMUP];
    end
    if (wr && paddr == ADDR_CMP_CTRL) begin
      s_d.cmp_mode = pwdata[3:0];
      s_d.adc_en = pwdata[BIT_ADC_EN];
    end
    if (wr && paddr == ADDR_CMP_VALUE) begin
      s_d.cmp_val = pwdata[15:0];
    end
    if (irq_wr) begin
      s_d.ovf_ie = pwdata[BIT_OVF_IE];
    end
    // count: write first, then event clear, then increment
    if (cnt_wr) begin
      s_d.count = pwdata[15:0];
    end else if (sev) begin
      s_d.count = COUNT_RESET;
    end else if (inc) begin
      s_d.count = s_q.count + COUNT_STEP;
    end
    // overflow flag: write one clears, a new wrap wins
    if (irq_wr && pwdata[BIT_OVF_FLAG]) begin
      s_d.ovf_flag = 1'b0;
    end
    if (ovf_set) begin
      s_d.ovf_flag = 1'b1;
    end
    // conversion only if the converter is enabled now
    s_d.adc_start = sev & s_q.adc_en;
    // clock mode; a failed oscillator drops back to primary
    case (s_q.mode)
      MODE_PRIMARY: begin
        if (scs_wr_sec && !clock_fail) begin
          s_d.mode = MODE_SECONDARY_RUN_MODE;
        end
      end
      MODE_SECONDARY_RUN_MODE: begin
        if (clock_fail) begin
          s_d.mode = MODE_PRIMARY;
        end else if (osc_wr && !scs_wr_sec) begin
          s_d.mode = MODE_PRIMARY;
        end else if (sleep_exec && !s_q.idle_on_sleep) begin
          s_d.mode = MODE_SECONDARY_IDLE_MODE;
        end
      end
      MODE_SECONDARY_IDLE_MODE: begin
        if (clock_fail) begin
          s_d.mode = MODE_PRIMARY;
        end else if (wake_event) begin
          s_d.mode = MODE_SECONDARY_RUN_MODE;
        end
      end
      default: s_d.mode = MODE_PRIMARY;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= CORE_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // oscillator enable ignores sleep, so it runs in every mode
  assign secondary_osc_enable = s_q.osc_en | s_q.osc_en_t3 | s_q.warmup
    | (s_q.system_clock_select == SCS_SECONDARY);
  assign osc_drive_high = (s_q.drive_cfg == DRIVE_HIGH);
  assign osc_drive_low = (s_q.drive_cfg == DRIVE_LOW);
  assign secondary_run_mode = (s_q.mode == MODE_SECONDARY_RUN_MODE);
  assign secondary_idle_mode = (s_q.mode == MODE_SECONDARY_IDLE_MODE);
  // cpu stops in secondary idle, peripherals keep pclk
  assign cpu_halt = (s_q.mode == MODE_SECONDARY_IDLE_MODE);
  assign overflow_irq = s_q.ovf_flag & s_q.ovf_ie;
  assign adc_start = s_q.adc_start;
  assign prdata = s_q.rdata;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_wrap_edge;
    inc && !cnt_wr && !sev && s_q.count == COUNT_MAX;
  endsequence

  sequence s_clear_edge;
    sev && !cnt_wr;
  endsequence

  a_osc_select_on: assert property (
    (s_q.system_clock_select == SCS_SECONDARY || s_q.warmup) |-> secondary_osc_enable)
    else $error("oscillator off while requested");
  a_osc_sleep_run: assert property (
    (secondary_osc_enable && sleep_exec && !wr) |=> secondary_osc_enable)
    else $error("sleep stopped the oscillator");
  a_scs_run_entry: assert property (
    (scs_wr_sec && !clock_fail && s_q.mode == MODE_PRIMARY)
      |=> secondary_run_mode && !cpu_halt)
    else $error("clock select did not enter secondary run");
  a_sleep_idle_entry: assert property (
    (secondary_run_mode && sleep_exec && !s_q.idle_on_sleep
      && !clock_fail && !osc_wr) |=> secondary_idle_mode && cpu_halt)
    else $error("sleep did not enter secondary idle");
  a_fail_clears_flag: assert property (
    clock_fail |=> !flag_active [*2])
    else $error("active flag held after oscillator failure");
  a_drive_level_map: assert property (
    osc_drive_low |-> !osc_drive_high && s_q.drive_cfg == DRIVE_LOW)
    else $error("drive level decode wrong");
  a_count_wrap_flag: assert property (
    s_wrap_edge |=> s_q.count == COUNT_RESET && s_q.ovf_flag)
    else $error("wrap did not zero count and set flag");
  a_irq_enable_gate: assert property (
    (s_q.ovf_flag && !s_q.ovf_ie && !irq_wr) |=> !overflow_irq)
    else $error("interrupt raised while disabled");
  a_event_clear: assert property (
    s_clear_edge |=> s_q.count == COUNT_RESET)
    else $error("special event did not clear count");
  a_event_adc_start: assert property (
    (sev && s_q.adc_en) |=> adc_start ##1 !adc_start)
    else $error("conversion start missing or too long");
  a_write_beats_event: assert property (
    cnt_wr |=> s_q.count == $past(pwdata[15:0]))
    else $error("count write lost");
  a_clear_no_flag: assert property (
    (s_clear_edge ##0 !s_q.ovf_flag) |=> !s_q.ovf_flag)
    else $error("event clear set the overflow flag");
  a_gate_hold: assert property (
    (s_q.gate_enable && !gif.gate_active && !cnt_wr && !sev)
      |=> $stable(s_q.count))
    else $error("counted while gate closed");
  a_free_running: assert property (
    (inc && !s_q.gate_enable && !cnt_wr && !sev)
      |=> s_q.count == 16'($past(s_q.count) + COUNT_STEP))
    else $error("free-running count missed an edge");
  a_pin_polarity_low: assert property (
    (s_q.gate_source_select == GSS_PIN && !s_q.gate_polarity)
      |-> gif.gate_active == !u_sel.s_q.pin_s[1])
    else $error("low polarity gate decode wrong");
  a_osc_timer_bits: assert property (
    (s_q.osc_en || s_q.osc_en_t3) |-> secondary_osc_enable)
    else $error("timer oscillator enable bit ignored");
  a_irq_raised: assert property (
    (s_q.ovf_flag && s_q.ovf_ie) |-> overflow_irq)
    else $error("enabled overflow raised no interrupt");
  a_primary_no_idle: assert property (
    (s_q.mode == MODE_PRIMARY && sleep_exec) |=> !secondary_idle_mode)
    else $error("secondary idle entered from primary clock");
  a_timer2_route: assert property (
    (s_q.gate_source_select == GSS_TIMER2)
      |-> gif.gate_level == u_sel.s_q.t2_pulse)
    else $error("timer2 match pulse not routed to the gate");
  a_cmp1_route: assert property (
    (s_q.gate_source_select == GSS_CMP1)
      |-> gif.gate_level == u_sel.s_q.c1_s[1])
    else $error("comparator 1 not routed to the gate");
  a_count_hold_off: assert property (
    (!s_q.timer_on && !cnt_wr) |=> $stable(s_q.count))
    else $error("stopped counter changed");
endmodule // gce_counter

// ==== verif/gce_src_model.sv ====
// source model: timer clock pin bursts driven on request
module gce_src_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // burst request from the bench
  input wire logic go,
  input wire logic [7:0] n,
  // pin side
  output logic timer_clk_pin,
  output logic done
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] left_q;
  logic [2:0] ph_q;
  // one pin period per eight pclk, so every edge is seen synchronously
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      left_q <= 8'h00;
      ph_q <= 3'h0;
    end else if (go) begin
      left_q <= n;
      ph_q <= 3'h0;
    end else if (left_q != 8'h00) begin
      ph_q <= ph_q + 3'h1;
      if (ph_q == 3'h7) left_q <= left_q - 8'h01;
    end
  end
  // pin rests low between bursts, high in the second half of each period
  assign timer_clk_pin = (left_q != 8'h00) && ph_q[2];
  assign done = (left_q == 8'h00);
endmodule // gce_src_model

// ==== verif/testbench.sv ====
// testbench: registers, oscillator, modes, counter, trigger and gate
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import gce_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, n_q;
  logic [31:0] pwdata, prdata, modes;
  logic tck, gpin, c1, c2, slp, wak, cfl, go, done;
  logic [7:0] t2p;
  logic osc_en, drv_h, drv_l, run_m, idle_m, halt, irq, adc;
  int num_errors = 0;
  int tests_run = 0;
  int adc_cnt = 0;
  logic [7:0] ta[6] = '{8'h00, 8'h00, 8'h10, 8'h0C, 8'h0C, 8'h00};
  logic [7:0] td[6] = '{8'h08, 8'h10, 8'h08, 8'h01, 8'h02, 8'h01};
  logic te[6] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
  logic [4:0] cm_t[3] = '{5'h1B, 5'h0B, 5'h1A};
  assign modes = {29'h0, run_m, idle_m, halt};
  gce_counter dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_clk_pin(tck), .gate_input_pin(gpin), .cmp1_out(c1),
    .cmp2_out(c2), .timer2_count(8'h00), .timer2_period(t2p),
    .sleep_exec(slp), .wake_event(wak), .clock_fail(cfl),
    .secondary_osc_enable(osc_en), .osc_drive_high(drv_h),
    .osc_drive_low(drv_l), .secondary_run_mode(run_m),
    .secondary_idle_mode(idle_m), .cpu_halt(halt), .overflow_irq(irq),
    .adc_start(adc));
  gce_src_model src_u (.pclk(pclk), .presetn(presetn), .go(go), .n(n_q),
    .timer_clk_pin(tck), .done(done));
  // clock
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // conversion start pulses, counted for the trigger checks
  always @(posedge pclk) if (adc === 1'b1) adc_cnt++;
  task automatic give_verdict;
    $display("tests_run=%0d num_errors=%0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // no limit here: the watchdog ends a wait that never finishes
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, exp);
  endtask
  // n timer clock edges, then settle past the synchroniser
  task automatic ticks(input logic [7:0] n);
    @(posedge pclk);
    go <= 1'b1;
    n_q <= n;
    @(posedge pclk);
    go <= 1'b0;
    @(posedge pclk);
    for (int i = 0; i < 4000 && done !== 1'b1; i++) @(posedge pclk);
    repeat (6) @(posedge pclk);
  endtask
  // one-cycle pulse: 0 sleep, 1 wake, 2 clock fail
  task automatic pm(input int k);
    @(posedge pclk);
    {slp, wak, cfl} <= 3'b100 >> k;
    @(posedge pclk);
    {slp, wak, cfl} <= 3'b000;
    @(posedge pclk);
  endtask
  function automatic logic [15:0] exp_cnt(input logic [15:0] s,
      input int n, input logic sev, input logic [15:0] c);
    for (int i = 0; i < n; i++) begin
      s = s + 16'h0001;
      if (sev && s == c) s = 16'h0000;
    end
    return s;
  endfunction
  // watchdog, well beyond the expected run length
  initial begin
    repeat (60000) @(posedge pclk);
    num_errors++;
    give_verdict();
  end
  initial begin
    logic [31:0] r;
    logic e, lv;
    logic [2:0] gv;
    logic [7:0] n;
    int a0;
    {presetn, psel, penable, pwrite, go, slp, wak, cfl} = 8'h00;
    {gpin, c1, c2} = 3'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    n_q = 8'h00;
    t2p = 8'hFF;
    void'($urandom(62));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd(ADDR_COUNT, 32'h0);
    apb(1'b0, 8'h20, 32'h0, r, e);
    chk({r[30:0], e}, 32'h1);
    // every enable path alone starts the oscillator
    for (int k = 0; k < 6; k++) begin
      wr(ta[k], {24'h0, td[k]});
      @(posedge pclk);
      chk({31'h0, osc_en}, {31'h0, te[k]});
      wr(ta[k], 32'h0);
    end
    wr(ADDR_OSC_CTRL, 32'h30);
    @(posedge pclk);
    chk({30'h0, drv_h, drv_l}, 32'h2);
    wr(ADDR_OSC_CTRL, 32'h10);
    @(posedge pclk);
    chk({30'h0, drv_h, drv_l}, 32'h1);
    // mode walk: run, idle, wake, sleep ignored, clock failure
    // warm the oscillator and give it a start-up delay before use
    wr(ADDR_OSC_CTRL_TWO, 32'h8);
    repeat (16) @(posedge pclk);
    wr(ADDR_OSC_CTRL, 32'h01);
    @(posedge pclk);
    chk(modes, 32'h4);
    rd(ADDR_OSC_CTRL_TWO, 32'h48);
    pm(0);
    chk(modes, 32'h3);
    chk({31'h0, osc_en}, 32'h1);
    pm(1);
    chk(modes, 32'h4);
    wr(ADDR_OSC_CTRL, 32'h81);
    pm(0);
    chk(modes, 32'h4);
    pm(2);
    chk(modes, 32'h0);
    rd(ADDR_OSC_CTRL_TWO, 32'h08);
    wr(ADDR_OSC_CTRL, 32'h0);
    wr(ADDR_OSC_CTRL_TWO, 32'h0);
    // wrap through the top of the count, flag and enable
    wr(ADDR_TMR_CTRL, 32'h1);
    wr(ADDR_COUNT, 32'hFFFD);
    ticks(8'd5);
    rd(ADDR_COUNT, {16'h0, exp_cnt(16'hFFFD, 5, 1'b0, 16'h0)});
    rd(ADDR_IRQ, 32'h1);
    chk({31'h0, irq}, 32'h0);
    wr(ADDR_IRQ, 32'h2);
    @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    wr(ADDR_IRQ, 32'h3);
    rd(ADDR_IRQ, 32'h2);
    wr(ADDR_IRQ, 32'h0);
    // compare trigger: only mode 1011 clears, start needs converter on
    wr(ADDR_CMP_VALUE, 32'h5);
    for (int k = 0; k < 3; k++) begin
      wr(ADDR_CMP_CTRL, {27'h0, cm_t[k]});
      wr(ADDR_COUNT, 32'h0);
      a0 = adc_cnt;
      ticks(8'd8);
      rd(ADDR_COUNT, {16'h0, exp_cnt(16'h0, 8, cm_t[k][3:0] == 4'hB,
        16'h5)});
      chk(32'(adc_cnt - a0), {31'h0, cm_t[k] == 5'h1B});
      rd(ADDR_IRQ, 32'h0);
    end
    wr(ADDR_CMP_CTRL, 32'h0);
    // every gate source, polarity and enable with random levels
    for (int g = 0; g < 16; g++) begin
      gv = 3'($urandom);
      n = 8'($urandom_range(20, 1));
      {gpin, c1, c2} <= gv;
      case (g[1:0])
        GSS_PIN: lv = gv[2];
        GSS_CMP1: lv = gv[1];
        GSS_CMP2: lv = gv[0];
        default: lv = 1'b0;
      endcase
      wr(ADDR_GATE_CTRL, {24'h0, g[3], g[2], 4'h0, g[1:0]});
      wr(ADDR_COUNT, 32'h0);
      ticks(n);
      n = (!g[3] || (g[2] == lv)) ? n : 8'h0;
      rd(ADDR_COUNT, {24'h0, n});
      rd(ADDR_GATE_CTRL, {24'h0, g[3:2], 3'h0, lv, g[1:0]});
    end
    // timer2 match pulse on the gate level status, one cycle only
    wr(ADDR_GATE_CTRL, 32'h41);
    @(posedge pclk);
    t2p <= 8'h00;
    @(posedge pclk);
    t2p <= 8'hFF;
    rd(ADDR_GATE_CTRL, 32'h45);
    rd(ADDR_GATE_CTRL, 32'h41);
    give_verdict();
  end
endmodule // testbench
